// File: rtl/capture_defines.svh
`ifndef CAPTURE_DEFINES_SVH
`define CAPTURE_DEFINES_SVH
// Capture mode field encodings (4-bit control field)
`define CAP_MODE_OFF 4'h0
`define CAP_MODE_FALL 4'h4
`define CAP_MODE_RISE 4'h5
`define CAP_MODE_RISE4 4'h6
`define CAP_MODE_RISE16 4'h7
// Prescaler ratios
`define CAP_RATIO_4 4'h3
`define CAP_RATIO_16 4'hf
// Bit position of the capture flag in the peripheral flag register
`define CAP_FLAG_BIT 2
// Reset values
`define CAP_PRESCALE_RST 4'h0
`define CAP_VALUE_RST 16'h0000
`endif

// File: rtl/capture_pkg.sv
package capture_pkg;
  // Captured value as a byte pair
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } capture_pair_s;
  // Control setting carried together
  typedef struct packed {
    logic [3:0] mode;
    logic timer_select;
  } capture_cfg_s;
endpackage : capture_pkg

// File: rtl/input_edge_capture_unit.sv
`timescale 1ns/1ps
`include "capture_defines.svh"
// What this block does, and what its software and timer must do
// [RL1] Selected event copies timer count to pair
// [RL2] Mode picks fall, rise, 4th, 16th rise
// [RL3] Capture sets flag; only software clears
// [RL4] New capture overwrites unread value
// [RL5] Software sets pin direction to input
// [RL6] Port writes on output pin can capture
// [RL7] Timer must run synchronised, not asynchronous
// [RL8] Timer B control picks sampled timer
// [RL9] Mode change may set spurious flag
// [RL10] Prescaler held zero when off
// [RL11] Direct ratio switch keeps prescaler count
// [RL12] Software turns unit off before switch
// [RL13] Flag sets regardless of enables
// [RL14] Software clears flag before enabling
// [RL15] Pin synchronised, edge latches timer value
module input_edge_capture_unit #(
  parameter int TIMER_WIDTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic capture_input_pin,
  input wire logic port_c_out,
  input wire logic port_c_direction,
  input wire logic [TIMER_WIDTH-1:0] timer_a_count,
  input wire logic [TIMER_WIDTH-1:0] timer_b_count,
  input wire capture_pkg::capture_cfg_s capture_cfg,
  input wire logic capture_irq_flag_clear,
  input wire logic capture_irq_enable,
  output capture_pkg::capture_pair_s capture_value_pair,
  output logic capture_irq_flag,
  output logic capture_irq,
  output logic [3:0] prescale_count
);
  import capture_pkg::*;

  // ************************************************
  // Parameter check
  // ************************************************
  if (TIMER_WIDTH != 16) begin : g_bad_width
    $error("Capture pair holds exactly 16 bits");
  end

  // ************************************************
  // Pin level and synchroniser
  // ************************************************
  logic pin_level; // Output drive when direction is output, else external pin
  logic sync1_reg; // First stage, read only by second stage
  logic sync2_reg; // Second stage
  logic prev_reg; // Delayed copy for edge detection
  logic sync1_next;
  logic sync2_next;
  logic prev_next;

  // Direction low means driven output; port writes then reach the edge path
  always_comb begin
    pin_level = port_c_direction ? capture_input_pin : port_c_out; // RL6
    sync1_next = pin_level; // RL15
    sync2_next = sync1_reg;
    prev_next = sync2_reg;
  end

  // Synchroniser registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
    end
  end

  // ************************************************
  // Event qualification and prescaler
  // ************************************************
  logic rise_edge; // Rising edge on synchronised pin
  logic fall_edge; // Falling edge on synchronised pin
  logic capture_mode; // Mode field is one of the capture modes
  logic capture_event; // Qualifying event this cycle
  logic [3:0] prescale_reg; // Rising-edge prescaler counter
  logic [3:0] prescale_next;
  logic [3:0] mode_prev_reg; // Previous mode, to spot changes
  logic [3:0] mode_prev_next;

  // Edge detect and mode decode
  always_comb begin
    rise_edge = sync2_reg & ~prev_reg; // RL15
    fall_edge = ~sync2_reg & prev_reg; // RL15
    capture_mode = (capture_cfg.mode >= `CAP_MODE_FALL) &&
                   (capture_cfg.mode <= `CAP_MODE_RISE16);
    prescale_next = prescale_reg;
    capture_event = 1'b0;
    mode_prev_next = capture_cfg.mode;
    if (!capture_mode) begin
      // Off or other mode: counter held clear, so reset clears it too
      prescale_next = `CAP_PRESCALE_RST; // RL10
    end else begin
      // Counter not cleared on ratio change; first capture may come early
      case (capture_cfg.mode) // RL2 RL11
        `CAP_MODE_FALL: begin
          capture_event = fall_edge;
        end
        `CAP_MODE_RISE: begin
          capture_event = rise_edge;
        end
        `CAP_MODE_RISE4: begin
          if (rise_edge) begin
            // Low two bits pick every fourth edge of the free-running count
            capture_event = ({2'h0, prescale_reg[1:0]} == `CAP_RATIO_4);
            prescale_next = prescale_reg + 4'h1;
          end
        end
        default: begin
          if (rise_edge) begin
            capture_event = (prescale_reg == `CAP_RATIO_16);
            prescale_next = prescale_reg + 4'h1;
          end
        end
      endcase
    end
  end

  // Prescaler and mode history registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prescale_reg <= `CAP_PRESCALE_RST;
      mode_prev_reg <= `CAP_MODE_OFF;
    end else begin
      prescale_reg <= prescale_next;
      mode_prev_reg <= mode_prev_next;
    end
  end

  // ************************************************
  // Capture register and flag
  // ************************************************
  logic mode_switch; // Switch between two capture modes
  capture_pair_s value_reg; // Captured timer value
  capture_pair_s value_next;
  logic flag_reg; // Capture flag
  logic flag_next;

  // Latch timer and raise flag; set beats clear
  always_comb begin
    mode_switch = capture_mode && (mode_prev_reg != capture_cfg.mode) &&
                  (mode_prev_reg >= `CAP_MODE_FALL) &&
                  (mode_prev_reg <= `CAP_MODE_RISE16);
    value_next = value_reg;
    if (capture_event) begin
      // Overwrite unconditionally; unread value is lost
      value_next = capture_cfg.timer_select ? timer_b_count : timer_a_count; // RL1 RL4 RL8
    end
    flag_next = flag_reg;
    if (capture_irq_flag_clear) begin
      flag_next = 1'b0; // RL3
    end
    // Spurious flag on direct mode switch; software clears it afterwards
    if (capture_event || mode_switch) begin
      flag_next = 1'b1; // RL3 RL9 RL11 RL13
    end
  end

  // Capture registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      value_reg <= `CAP_VALUE_RST;
      flag_reg <= 1'b0;
    end else begin
      value_reg <= value_next;
      flag_reg <= flag_next;
    end
  end

  // Outputs
  assign capture_value_pair = value_reg;
  assign capture_irq_flag = flag_reg;
  assign capture_irq = flag_reg & capture_irq_enable;
  assign prescale_count = prescale_reg;

  // ************************************************
  // Assertions
  // ************************************************
  // Rising edge as the detector sees it, one cycle long
  sequence s_rise_seen;
    sync2_reg && !prev_reg;
  endsequence

  AST_EVENT_SETS_FLAG: assert property (@(posedge clk_sys) disable iff (rst) // RL3
    capture_event |=> flag_reg)
    else $error("Capture did not set flag");
  AST_FLAG_NO_HW_CLEAR: assert property (@(posedge clk_sys) disable iff (rst) // RL3
    flag_reg && !capture_irq_flag_clear |=> flag_reg)
    else $error("Flag cleared without software");
  AST_VALUE_A: assert property (@(posedge clk_sys) disable iff (rst) // RL1
    capture_event && !capture_cfg.timer_select |=> value_reg == $past(timer_a_count))
    else $error("Timer A value not captured");
  AST_VALUE_B: assert property (@(posedge clk_sys) disable iff (rst) // RL8
    capture_event && capture_cfg.timer_select |=> value_reg == $past(timer_b_count))
    else $error("Timer B value not captured");
  AST_PRESCALE_OFF: assert property (@(posedge clk_sys) disable iff (rst) // RL10
    !capture_mode |=> prescale_reg == 4'h0)
    else $error("Prescaler not held at zero");
  AST_RISE_MODE: assert property (@(posedge clk_sys) disable iff (rst) // RL2
    ((capture_cfg.mode == `CAP_MODE_RISE) and s_rise_seen) |-> capture_event)
    else $error("Rising edge missed");
  AST_FALL_MODE: assert property (@(posedge clk_sys) disable iff (rst) // RL2
    capture_cfg.mode == `CAP_MODE_FALL && rise_edge |-> !capture_event)
    else $error("Rising edge captured in falling mode");
  AST_SYNC_LATENCY: assert property (@(posedge clk_sys) disable iff (rst) // RL15
    $rose(sync1_reg) ##1 1 |-> sync2_reg && !prev_reg)
    else $error("Synchroniser latency wrong");
  AST_HOLD_VALUE: assert property (@(posedge clk_sys) disable iff (rst) // RL4
    !capture_event |=> $stable(value_reg))
    else $error("Value changed without event");
  AST_FLAG_ENABLE_FREE: assert property (@(posedge clk_sys) disable iff (rst) // RL13
    capture_event && !capture_irq_enable |=> capture_irq_flag)
    else $error("Flag gated by enable");

  // ************************************************
  // Pin path checks
  // ************************************************
  // A rise of the pin level reaches the edge detector two edges later;
  // a shorter path would mean a synchroniser stage had been bypassed
  sequence s_rise_arrives;
    ##2 rise_edge;
  endsequence
  // Same two-edge path for a fall of the pin level
  sequence s_fall_arrives;
    ##2 fall_edge;
  endsequence

  // External rise shows up as a rising edge after the synchroniser
  AST_PIN_RISE_PATH: assert property (@(posedge clk_sys) disable iff (rst) // RL15
    $rose(pin_level) |-> s_rise_arrives)
    else $error("Pin rise not seen after two edges");
  // External fall shows up as a falling edge after the synchroniser
  AST_PIN_FALL_PATH: assert property (@(posedge clk_sys) disable iff (rst) // RL15
    $fell(pin_level) |-> s_fall_arrives)
    else $error("Pin fall not seen after two edges");
  // A port write on a pin driven as output travels the external path;
  // direction must be steady, else the level jump is a switch artefact
  AST_PORT_WRITE_EDGE: assert property (@(posedge clk_sys) disable iff (rst) // RL6
    !port_c_direction && $stable(port_c_direction) &&
    $rose(port_c_out) |-> s_rise_arrives)
    else $error("Port write did not reach edge detector");

  // ************************************************
  // Prescaler checks
  // ************************************************
  // The counter runs free through all sixteen values; the four-edge
  // mode reads only its low two bits, so a switch keeps its phase
  // In the four-edge mode each rising edge advances the counter by one
  AST_RISE4_ADVANCE: assert property (@(posedge clk_sys) disable iff (rst) // RL2
    capture_cfg.mode == `CAP_MODE_RISE4 && rise_edge |=>
      prescale_reg == $past(prescale_reg) + 4'h1)
    else $error("Prescaler did not advance");
  // The fourth edge of each group of four captures
  AST_RISE4_FOURTH: assert property (@(posedge clk_sys) disable iff (rst) // RL2
    capture_cfg.mode == `CAP_MODE_RISE4 && rise_edge && prescale_reg[1:0] == 2'h3 |->
      capture_event)
    else $error("Fourth rising edge missed");
  // Other counter phases never capture in the four-edge mode
  AST_RISE4_SKIP: assert property (@(posedge clk_sys) disable iff (rst) // RL2
    capture_cfg.mode == `CAP_MODE_RISE4 && prescale_reg[1:0] != 2'h3 |-> !capture_event)
    else $error("Capture before fourth rising edge");
  // The sixteenth edge captures in the sixteen-edge mode
  AST_RISE16_LAST: assert property (@(posedge clk_sys) disable iff (rst) // RL2
    capture_cfg.mode == `CAP_MODE_RISE16 && rise_edge && prescale_reg == `CAP_RATIO_16 |->
      capture_event)
    else $error("Sixteenth rising edge missed");
  // Other counter values never capture in the sixteen-edge mode
  AST_RISE16_SKIP: assert property (@(posedge clk_sys) disable iff (rst) // RL2
    capture_cfg.mode == `CAP_MODE_RISE16 && prescale_reg != `CAP_RATIO_16 |-> !capture_event)
    else $error("Capture before sixteenth rising edge");
  // Edges are ignored while the unit is off or outside the capture modes,
  // so a pin toggling during set-up never disturbs the stored value
  AST_OFF_NO_EVENT: assert property (@(posedge clk_sys) disable iff (rst) // RL10
    !capture_mode |-> !capture_event)
    else $error("Capture while unit is off");

  // ************************************************
  // Mode switch and flag checks
  // ************************************************
  // A direct switch between capture modes raises the spurious flag,
  // which is why software keeps the request masked around a change
  AST_SWITCH_SETS_FLAG: assert property (@(posedge clk_sys) disable iff (rst) // RL9
    mode_switch |=> flag_reg)
    else $error("Mode switch did not set flag");
  // A direct switch leaves the counter where it was, so the first
  // capture afterwards can come after fewer edges than the new ratio
  AST_SWITCH_KEEPS_COUNT: assert property (@(posedge clk_sys) disable iff (rst) // RL11
    mode_switch && !rise_edge |=> prescale_reg == $past(prescale_reg))
    else $error("Mode switch changed prescaler");
  // A software clear with nothing to set drops the flag on the next edge;
  // set wins over clear, so a clear in a capture cycle is lost
  AST_FLAG_CLEARS: assert property (@(posedge clk_sys) disable iff (rst) // RL3
    capture_irq_flag_clear && !capture_event && !mode_switch |=> !flag_reg)
    else $error("Software clear ignored");
endmodule : input_edge_capture_unit

// File: sim/capture_pin_model.sv
`timescale 1ns/1ps
// ****************
// External event source on the capture pin
// ****************
module capture_pin_model (
  input wire logic clk_sys,
  output logic capture_input_pin
);
  // Starts low so the first seen edge is a rising one
  initial capture_input_pin = 1'b0;
  // Moves off the falling edge; holds 4 cycles so two-stage sync sees it
  task automatic drive_level(input logic level);
    @(negedge clk_sys);
    capture_input_pin = level;
    repeat (4) @(negedge clk_sys);
  endtask : drive_level
  // Whole pulses only, so the pin always idles low between calls
  task automatic pulse(input int count);
    for (int i = 0; i < count; i++) begin
      drive_level(1'b1);
      drive_level(1'b0);
    end
  endtask : pulse
endmodule : capture_pin_model

// File: sim/input_edge_capture_unit_tb.sv
`timescale 1ns/1ps
module input_edge_capture_unit_tb;
  import capture_pkg::*;
  // ****************
  // Stimulus and observed signals
  // ****************
  logic clk_sys = 1'b0;
  logic rst;
  logic pin;
  logic port_c_out;
  logic port_c_direction;
  logic [15:0] tim_a; // Held steady, as a synchronised timer
  logic [15:0] tim_b;
  capture_cfg_s cfg;
  logic clr;
  logic ena;
  capture_pair_s pair;
  logic flag;
  logic irq;
  logic [3:0] cnt;
  int num_errors = 0;
  int comparisons = 0;
  always #2 clk_sys = ~clk_sys;
  capture_pin_model i_pin (.clk_sys(clk_sys), .capture_input_pin(pin));
  input_edge_capture_unit i_dut (.clk_sys(clk_sys), .rst(rst), .capture_input_pin(pin),
    .port_c_out(port_c_out), .port_c_direction(port_c_direction), .timer_a_count(tim_a),
    .timer_b_count(tim_b), .capture_cfg(cfg), .capture_irq_flag_clear(clr),
    .capture_irq_enable(ena), .capture_value_pair(pair), .capture_irq_flag(flag),
    .capture_irq(irq), .prescale_count(cnt));
  // Four-state compare so an unknown never passes
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // New setting, then a clear pulse to drop any spurious flag from the change
  task automatic setup(input logic [3:0] m, input logic s);
    @(negedge clk_sys);
    cfg = '{mode: m, timer_select: s};
    repeat (2) @(negedge clk_sys);
    clr = 1'b1;
    @(negedge clk_sys);
    clr = 1'b0;
  endtask : setup
  task automatic t_rise;
    setup(4'h5, 1'b0);
    i_pin.pulse(1);
    chk("pair", pair, 16'h1234);
    chk("flag", flag, 1'b1);
    chk("irq", irq, 1'b0);
    setup(4'h5, 1'b0);
    chk("flag", flag, 1'b0);
    ena = 1'b1;
    i_pin.pulse(1);
    chk("irq", irq, 1'b1);
    setup(4'h5, 1'b0);
    chk("irq", irq, 1'b0);
    ena = 1'b0;
    $display("rise test done");
  endtask : t_rise
  task automatic t_fall;
    setup(4'h4, 1'b1);
    i_pin.drive_level(1'b1);
    chk("pair", pair, 16'h1234);
    i_pin.drive_level(1'b0);
    chk("pair", pair, 16'habcd);
    $display("fall test done");
  endtask : t_fall
  task automatic t_prescale;
    tim_a = 16'h0f0f;
    setup(4'h0, 1'b0);
    chk("count", cnt, 4'h0);
    setup(4'h6, 1'b0);
    i_pin.pulse(3);
    chk("count", cnt, 4'h3);
    chk("flag", flag, 1'b0);
    i_pin.pulse(1);
    chk("pair", pair, 16'h0f0f);
    chk("count", cnt, 4'h4);
    i_pin.pulse(2);
    setup(4'h6, 1'b0);
    chk("flag", flag, 1'b0);
    @(negedge clk_sys);
    cfg.mode = 4'h7;
    repeat (3) @(negedge clk_sys);
    chk("count", cnt, 4'h6);
    chk("flag", flag, 1'b1);
    setup(4'h7, 1'b0);
    i_pin.pulse(9);
    chk("flag", flag, 1'b0);
    i_pin.pulse(1);
    chk("flag", flag, 1'b1);
    chk("count", cnt, 4'h0);
    $display("prescale test done");
  endtask : t_prescale
  task automatic t_port;
    tim_b = 16'h5a5a;
    setup(4'h5, 1'b1);
    port_c_direction = 1'b0;
    repeat (3) @(negedge clk_sys);
    port_c_out = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk("pair", pair, 16'h5a5a);
    chk("flag", flag, 1'b1);
    $display("port test done");
  endtask : t_port
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // ****************
  // Main sequence
  // ****************
  initial begin
    rst = 1'b1;
    port_c_out = 1'b0;
    port_c_direction = 1'b1;
    tim_a = 16'h1234;
    tim_b = 16'habcd;
    cfg = '0;
    clr = 1'b0;
    ena = 1'b0;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    chk("pair", pair, 16'h0000);
    chk("count", cnt, 4'h0);
    t_rise();
    t_fall();
    t_prescale();
    t_port();
    report_and_stop();
  end
endmodule : input_edge_capture_unit_tb
